// ### accel_feature_config_regs.v
// Feature configuration registers with I2C access and interrupt pin shaping
`timescale 1ns/100ps
`default_nettype none
`include "accel_cfg_map.vh"
module accel_feature_config_regs (
  input wire clk_in,
  input wire sys_rst_in,
  input wire scl_in,
  input wire sda_in,
  output wire sda_oe_n_out,
  input wire motion_event_in,
  input wire motion_level_in,
  input wire tap_event_in,
  input wire orient_event_in,
  input wire reboot_done_in,
  output wire irq_pin_out,
  output wire irq_pin_oe_n_out,
  output reg reboot_busy_out,
  output reg operating_mode_bit,
  output reg [1:0] orient_rate_out,
  output reg [2:0] tap_rate_out,
  output reg [1:0] motion_rate_out,
  output reg [2:0] motion_axis_en_out,
  output reg [5:0] tap_dir_en_out,
  output reg tap_alt_mask_enable,
  output reg [1:0] highpass_rolloff_out,
  output reg [2:0] lowpass_rate_out,
  output reg lowpass_rate_valid_out
);
  reg [7:0] main_ctrl;
  reg [7:0] rate_and_reset_control;
  reg [7:0] irq_pin_config;
  reg [7:0] motion_axis_enable;
  reg [7:0] tap_direction_mask;
  reg [7:0] output_filter_config;
  reg [7:0] selftest_response_reg;
  reg [7:0] reg_ptr;
  reg [7:0] rd_data;
  reg irq_latched;
  reg [9:0] pulse_cnt;
  reg [7:0] reboot_cnt;
  reg [1:0] done_s;
  wire start_p;
  wire wr_p;
  wire [7:0] wr_byte;
  wire rd_p;
  wire addr_phase;
  wire nack_wr;
  wire irq_event;
  wire unlatched_mode;
  wire irq_active;
  wire pulse_mode;

  function [7:0] masked;
    input [7:0] value;
    input [7:0] mask;
    begin
      masked = value & mask;
    end
  endfunction

  i2c_target u_i2c (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_n_out(sda_oe_n_out),
    .nack_wr_in(nack_wr),
    .rd_data_in(rd_data),
    .start_out(start_p),
    .wr_strobe_out(wr_p),
    .wr_data_out(wr_byte),
    .rd_strobe_out(rd_p),
    .addr_phase_out(addr_phase)
  );

  // Data byte aimed at the reboot register; the engine checks its top bit
  assign nack_wr = ~addr_phase & (reg_ptr == `ADDR_RATE_RESET); // [RULE3]

  always @* begin
    case (reg_ptr)
      `ADDR_MAIN_CTRL: rd_data = main_ctrl;
      `ADDR_RATE_RESET: rd_data = rate_and_reset_control; // [RULE2]
      `ADDR_IRQ_PIN_CFG: rd_data = irq_pin_config;
      `ADDR_MOTION_AXIS: rd_data = motion_axis_enable;
      `ADDR_TAP_MASK: rd_data = tap_direction_mask;
      `ADDR_FILTER_CFG: rd_data = output_filter_config;
      `ADDR_SELFTEST_RESP: rd_data = selftest_response_reg;
      default: rd_data = 8'h00; // [RULE19]
    endcase
  end

  assign irq_event = motion_event_in | tap_event_in | orient_event_in;
  assign unlatched_mode = irq_pin_config[`BIT_IRQ_UNLATCH] &
    main_ctrl[`BIT_MOTION_EN] & ~main_ctrl[`BIT_TAP_EN] &
    ~main_ctrl[`BIT_ORIENT_EN]; // [RULE11]
  assign pulse_mode = irq_pin_config[`BIT_IRQ_PULSE];
  assign irq_active = unlatched_mode ? motion_level_in :
    (pulse_mode ? (pulse_cnt != 10'h000) : irq_latched); // [RULE10]
  // Pin drives only when enabled; level follows polarity bit
  assign irq_pin_oe_n_out = ~irq_pin_config[`BIT_IRQ_ON]; // [RULE8]
  assign irq_pin_out = irq_pin_config[`BIT_IRQ_POL] ? irq_active :
    ~irq_active; // [RULE9]

  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      main_ctrl <= `RST_MAIN_CTRL;
      rate_and_reset_control <= `RST_RATE_RESET;
      irq_pin_config <= `RST_IRQ_PIN_CFG;
      motion_axis_enable <= `RST_MOTION_AXIS;
      tap_direction_mask <= `RST_TAP_MASK;
      output_filter_config <= `RST_FILTER_CFG;
      selftest_response_reg <= `SELFTEST_DONE;
      reg_ptr <= 8'h00;
      irq_latched <= 1'b0;
      pulse_cnt <= 10'h000;
      reboot_cnt <= 8'h00;
      done_s <= 2'h0;
    end else begin
      done_s <= {done_s[0], reboot_done_in};
      if (wr_p && addr_phase) begin
        reg_ptr <= wr_byte;
      end else if (wr_p) begin
        reg_ptr <= reg_ptr + 8'h01;
        // Host is expected to be in standby here; writes are not blocked [RULE1]
        case (reg_ptr)
          `ADDR_MAIN_CTRL: main_ctrl <= wr_byte; // [RULE17]
          `ADDR_RATE_RESET: begin
            rate_and_reset_control <= masked(wr_byte, `MASK_RATE_RESET);
            if (wr_byte[`BIT_SELFTEST])
              selftest_response_reg <= `SELFTEST_SET; // [RULE5]
            if (wr_byte[`BIT_REBOOT])
              reboot_cnt <= `REBOOT_CYC; // [RULE2]
          end
          `ADDR_IRQ_PIN_CFG:
            irq_pin_config <= masked(wr_byte, `MASK_IRQ_PIN_CFG); // [RULE19]
          `ADDR_MOTION_AXIS:
            motion_axis_enable <= masked(wr_byte, `MASK_MOTION_AXIS);
          `ADDR_TAP_MASK:
            tap_direction_mask <= masked(wr_byte, `MASK_TAP_MASK);
          `ADDR_FILTER_CFG:
            output_filter_config <= masked(wr_byte, `MASK_FILTER_CFG);
          default: ;
        endcase
      end else if (rd_p) begin
        reg_ptr <= reg_ptr + 8'h01;
        if (reg_ptr == `ADDR_SELFTEST_RESP &&
            rate_and_reset_control[`BIT_SELFTEST]) begin
          rate_and_reset_control[`BIT_SELFTEST] <= 1'b0; // [RULE5]
          selftest_response_reg <= `SELFTEST_DONE;
        end
      end
      // Reboot runs a minimum time and waits for the memory loader
      if (reboot_cnt != 8'h00)
        reboot_cnt <= reboot_cnt - 8'h01;
      // A new reboot write in the same cycle wins over the end of the old one
      else if (rate_and_reset_control[`BIT_REBOOT] && done_s[1] && !wr_p)
        rate_and_reset_control[`BIT_REBOOT] <= 1'b0; // [RULE2]
      // Set wins over the release read
      if (irq_event)
        irq_latched <= 1'b1;
      else if (rd_p && reg_ptr == `ADDR_IRQ_RELEASE)
        irq_latched <= 1'b0; // [RULE18]
      if (irq_event && pulse_mode)
        pulse_cnt <= `PULSE_CYC; // [RULE10]
      else if (pulse_cnt != 10'h000)
        pulse_cnt <= pulse_cnt - 10'h001;
    end
  end

  always @* begin
    operating_mode_bit = main_ctrl[`BIT_OPMODE]; // [RULE17]
    reboot_busy_out = rate_and_reset_control[`BIT_REBOOT];
    orient_rate_out = rate_and_reset_control[6:5]; // [RULE4]
    // Range bit of the tap rate code lives outside this group
    tap_rate_out = {1'b0, rate_and_reset_control[3:2]}; // [RULE6]
    motion_rate_out = rate_and_reset_control[1:0]; // [RULE7]
    motion_axis_en_out = motion_axis_enable[7:5]; // [RULE12]
    tap_dir_en_out = tap_direction_mask[5:0]; // [RULE13]
    tap_alt_mask_enable = tap_direction_mask[6]; // [RULE14]
    highpass_rolloff_out = output_filter_config[5:4]; // [RULE15]
    lowpass_rate_out = output_filter_config[2:0];
    lowpass_rate_valid_out = (output_filter_config[2:0] != 3'h7); // [RULE16]
  end
endmodule // accel_feature_config_regs
`default_nettype wire

// ### accel_cfg_map.vh
// Register map, field positions, reset values and timing of the feature config block
// Notes on behaviour
// RULE1: Host clears operating mode bit (standby) before writing these registers.
// RULE2: Writing one to soft reboot bit starts reboot; bit reads one until done.
// RULE3: Write setting soft reboot bit is not acknowledged; reboot starts at once.
// RULE4: Orientation rate 00..11 gives 1.6, 6.3, 12.5, 50 Hz; default 12.5 Hz.
// RULE5: Self-test bit loads response with AA; reading response clears bit, loads 55.
// RULE6: Tap rate code range,hi,lo: 50,100,200,400,12.5,25,800,1600 Hz; default 400.
// RULE7: Motion rate 00..11 gives 25, 50, 100, 200 Hz; default 50 Hz.
// RULE8: Interrupt pin enable bit 5 lets the pin be driven; clear disables it.
// RULE9: Polarity bit 4: clear active low, set active high; resets to one.
// RULE10: Response bit clear latches pin until release read; set gives one short pulse.
// RULE11: Unlatched motion bit with only motion enabled makes pin follow motion.
// RULE12: Bits 7,6,5 enable X,Y,Z motion interrupts; reset to one.
// RULE13: Bits 5..0 enable tap directions X-,X+,Y-,Y+,Z-,Z+; reset to one.
// RULE14: Bit 6 of tap mask selects the alternate masking scheme.
// RULE15: High-pass roll-off field selects 7/8, 15/16, 31/32, 63/64 coefficient.
// RULE16: Low-pass rate codes 000..110 give 12.5..800 Hz; 111 undefined.
// RULE17: Operating mode bit 7 of main control: clear standby, set active.
// RULE18: Reading release register 1A clears latched sources, status and pin; this block clears only its latched pin state.
// RULE19: Reserved bits read as zero and writes to them are ignored.
`ifndef ACCEL_CFG_MAP_VH
`define ACCEL_CFG_MAP_VH
`define ADDR_MAIN_CTRL 8'h1B
`define ADDR_SELFTEST_RESP 8'h0C
`define ADDR_IRQ_RELEASE 8'h1A
`define ADDR_RATE_RESET 8'h1D
`define ADDR_IRQ_PIN_CFG 8'h1E
`define ADDR_MOTION_AXIS 8'h1F
`define ADDR_TAP_MASK 8'h20
`define ADDR_FILTER_CFG 8'h21
`define I2C_DEV_ADDR 7'h0F
`define RST_MAIN_CTRL 8'h00
`define RST_RATE_RESET 8'h4D
`define RST_IRQ_PIN_CFG 8'h10
`define RST_MOTION_AXIS 8'hE0
`define RST_TAP_MASK 8'h3F
`define RST_FILTER_CFG 8'h02
`define MASK_RATE_RESET 8'hFF
`define MASK_IRQ_PIN_CFG 8'h3C
`define MASK_MOTION_AXIS 8'hE0
`define MASK_TAP_MASK 8'h7F
`define MASK_FILTER_CFG 8'h37
`define SELFTEST_SET 8'hAA
`define SELFTEST_DONE 8'h55
`define BIT_OPMODE 7
`define BIT_REBOOT 7
`define BIT_SELFTEST 4
`define BIT_IRQ_ON 5
`define BIT_IRQ_POL 4
`define BIT_IRQ_PULSE 3
`define BIT_IRQ_UNLATCH 2
`define BIT_MOTION_EN 1
`define BIT_TAP_EN 2
`define BIT_ORIENT_EN 0
// Pulse of 40 us at the 100 ns clock, sized to the pulse counter
`define PULSE_CYC 10'h190
`define REBOOT_CYC 8'h40
`endif

// ### i2c_target.v
// I2C target byte engine: address match, byte receive, byte send, ack control
`timescale 1ns/100ps
`default_nettype none
`include "accel_cfg_map.vh"
module i2c_target (
  input wire clk_in,
  input wire sys_rst_in,
  input wire scl_in,
  input wire sda_in,
  output reg sda_oe_n_out,
  input wire nack_wr_in,
  input wire [7:0] rd_data_in,
  output reg start_out,
  output reg wr_strobe_out,
  output reg [7:0] wr_data_out,
  output reg rd_strobe_out,
  output reg addr_phase_out
);
  reg [1:0] scl_s;
  reg [1:0] sda_s;
  reg scl_d;
  reg sda_d;
  reg [7:0] shreg;
  reg [3:0] bitcnt;
  reg active;
  reg first;
  reg acking;
  reg sending;
  wire scl_rise;
  wire scl_fall;
  wire start_c;
  wire stop_c;
  assign scl_rise = scl_s[1] & ~scl_d;
  assign scl_fall = ~scl_s[1] & scl_d;
  assign start_c = scl_s[1] & scl_d & ~sda_s[1] & sda_d;
  assign stop_c = scl_s[1] & scl_d & sda_s[1] & ~sda_d;
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      sda_oe_n_out <= 1'b1;
      start_out <= 1'b0;
      wr_strobe_out <= 1'b0;
      wr_data_out <= 8'h00;
      rd_strobe_out <= 1'b0;
      addr_phase_out <= 1'b0;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      active <= 1'b0;
      first <= 1'b0;
      acking <= 1'b0;
      sending <= 1'b0;
    end else begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
      start_out <= 1'b0;
      wr_strobe_out <= 1'b0;
      rd_strobe_out <= 1'b0;
      if (start_c) begin
        active <= 1'b1;
        first <= 1'b1;
        bitcnt <= 4'h0;
        acking <= 1'b0;
        sending <= 1'b0;
        sda_oe_n_out <= 1'b1;
        start_out <= 1'b1;
      end else if (stop_c) begin
        active <= 1'b0;
        sda_oe_n_out <= 1'b1;
      end else if (active && scl_rise && !acking) begin
        // A byte being sent shifts on the fall only, or bits are skipped
        if (!sending)
          shreg <= {shreg[6:0], sda_s[1]};
        bitcnt <= bitcnt + 4'h1;
      end else if (active && scl_rise && acking && sending) begin
        // Host NACK ends the read burst
        if (sda_s[1])
          active <= 1'b0;
      end else if (active && scl_fall) begin
        if (acking) begin
          acking <= 1'b0;
          bitcnt <= 4'h0;
          if (sending) begin
            shreg <= rd_data_in;
            sda_oe_n_out <= rd_data_in[7];
            rd_strobe_out <= 1'b1;
          end else begin
            sda_oe_n_out <= 1'b1;
          end
        end else if (bitcnt == 4'h8) begin
          acking <= 1'b1;
          if (first) begin
            first <= 1'b0;
            if (shreg[7:1] == `I2C_DEV_ADDR) begin
              sending <= shreg[0];
              addr_phase_out <= 1'b1;
              sda_oe_n_out <= 1'b0;
            end else begin
              active <= 1'b0;
              sda_oe_n_out <= 1'b1;
            end
          end else if (sending) begin
            sda_oe_n_out <= 1'b1;
          end else begin
            wr_data_out <= shreg;
            wr_strobe_out <= 1'b1;
            // Refused when the reboot register is targeted with bit 7 set
            sda_oe_n_out <= nack_wr_in & shreg[`BIT_REBOOT]; // [RULE3]
          end
        end else if (sending) begin
          sda_oe_n_out <= shreg[6];
          shreg <= {shreg[6:0], 1'b0};
        end
      end
      if (wr_strobe_out)
        addr_phase_out <= 1'b0;
    end
  end
endmodule // i2c_target
`default_nettype wire

// ### accel_cfg_checker_assertions.sv
// Port checker of the feature config block
`timescale 1ns/100ps
`default_nettype none
module accel_cfg_checker (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  input wire logic sda_oe_n_out,
  input wire logic reboot_done_in,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe_n_out,
  input wire logic reboot_busy_out,
  input wire logic [1:0] orient_rate_out,
  input wire logic [2:0] tap_rate_out,
  input wire logic [1:0] motion_rate_out,
  input wire logic [2:0] motion_axis_en_out,
  input wire logic [5:0] tap_dir_en_out,
  input wire logic [2:0] lowpass_rate_out,
  input wire logic lowpass_rate_valid_out
);
  logic [6:0] busy_cyc;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_no_ack;
    sda_oe_n_out [*8];
  endsequence
  // Saturates so a stuck reboot cannot wrap the count
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      busy_cyc <= 7'h00;
    else if (!reboot_busy_out)
      busy_cyc <= 7'h00;
    else if (busy_cyc != 7'h7F)
      busy_cyc <= busy_cyc + 7'h01;
  end
  AST_RST_RATES: assert property (
    $fell(sys_rst_in) |-> orient_rate_out == 2'h2 &&
    tap_rate_out == 3'h3 && motion_rate_out == 2'h1)
    else $error("rate fields wrong after reset");
  AST_RST_MASKS: assert property (
    $fell(sys_rst_in) |->
    motion_axis_en_out == 3'h7 && tap_dir_en_out == 6'h3F)
    else $error("masks wrong after reset");
  AST_RST_IRQ: assert property (
    $fell(sys_rst_in) |-> irq_pin_oe_n_out && !irq_pin_out)
    else $error("irq pin not idle after reset");
  AST_LP_VALID: assert property (
    lowpass_rate_valid_out == (lowpass_rate_out != 3'h7))
    else $error("lowpass valid flag wrong");
  AST_BUSY_MIN: assert property (
    $fell(reboot_busy_out) |-> busy_cyc >= 7'h40)
    else $error("reboot ended too early");
  AST_BUSY_HOLD: assert property (
    reboot_busy_out && !reboot_done_in |=> reboot_busy_out)
    else $error("reboot ended without done");
  AST_REBOOT_NACK: assert property (
    $rose(reboot_busy_out) |-> s_no_ack)
    else $error("reboot write was acknowledged");
  AST_SDA_SCL_LOW: assert property (
    $changed(sda_oe_n_out) |-> !$past(scl_in))
    else $error("data line moved with clock high");
endmodule // accel_cfg_checker
bind accel_feature_config_regs accel_cfg_checker chk_u (.*);
`default_nettype wire

// ### i2c_host_model.sv
// I2C host model: open-drain master at 800 ns per bit
`timescale 1ns/100ps
`default_nettype none
`include "accel_cfg_map.vh"
module i2c_host_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output var logic scl_out,
  output var logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic q();
    repeat (2) @(negedge clk_in);
  endtask
  // Data moves only while the clock is low; clock idles high between frames
  task automatic bit_io(input logic b, output logic s);
    sda_low_out = !b;
    q();
    scl_out = 1'b1;
    q();
    s = sda_in;
    q();
    scl_out = 1'b0;
    q();
  endtask
  task automatic start();
    sda_low_out = 1'b0;
    q();
    scl_out = 1'b1;
    q();
    sda_low_out = 1'b1;
    q();
    scl_out = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    q();
    scl_out = 1'b1;
    q();
    sda_low_out = 1'b0;
    q();
  endtask
  task automatic tx(input logic [7:0] v, output logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(v[i], s);
    bit_io(1'b1, s);
    ok = !s;
  endtask
  task automatic wr(input logic [7:0] a, v, output logic [2:0] k);
    start();
    tx({`I2C_DEV_ADDR, 1'b0}, k[2]);
    tx(a, k[1]);
    tx(v, k[0]);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic [2:0] k;
    logic s;
    start();
    tx({`I2C_DEV_ADDR, 1'b0}, k[2]);
    tx(a, k[1]);
    start();
    tx({`I2C_DEV_ADDR, 1'b1}, k[0]);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(1'b1, s);
    stop();
  endtask
endmodule // i2c_host_model
`default_nettype wire

// ### accel_feature_config_regs_tb_top.sv
// Self-checking bench of the feature config block over I2C
`timescale 1ns/100ps
`default_nettype none
`include "accel_cfg_map.vh"
module accel_feature_config_regs_tb_top;
  logic clk_in, sys_rst_in, host_low, tap_event_in, orient_event_in;
  logic motion_event_in, motion_level_in, reboot_done_in, scl_in;
  logic sda_oe_n_out, irq_pin_out, irq_pin_oe_n_out, reboot_busy_out;
  logic operating_mode_bit, tap_alt_mask_enable, lowpass_rate_valid_out;
  logic [1:0] orient_rate_out, motion_rate_out, highpass_rolloff_out;
  logic [2:0] tap_rate_out, motion_axis_en_out, lowpass_rate_out, k;
  logic [5:0] tap_dir_en_out;
  logic [7:0] d;
  int miscompares, num_checks;
  wire sda_in = !(host_low || !sda_oe_n_out);
  logic [7:0] ra [5] = '{`ADDR_RATE_RESET, `ADDR_IRQ_PIN_CFG,
    `ADDR_MOTION_AXIS, `ADDR_TAP_MASK, `ADDR_FILTER_CFG};
  logic [7:0] rv [5] = '{`RST_RATE_RESET, `RST_IRQ_PIN_CFG,
    `RST_MOTION_AXIS, `RST_TAP_MASK, `RST_FILTER_CFG};
  logic [7:0] rm [5] = '{`MASK_RATE_RESET, `MASK_IRQ_PIN_CFG,
    `MASK_MOTION_AXIS, `MASK_TAP_MASK, `MASK_FILTER_CFG};
  accel_feature_config_regs dut_u (.*);
  i2c_host_model host_u (.clk_in, .sda_in, .scl_out(scl_in),
    .sda_low_out(host_low));
  task automatic chk(input string n, input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Pin settings are written in standby, so every pin mode passes through it
  task automatic arm(input logic [7:0] cfg);
    host_u.wr(`ADDR_MAIN_CTRL, 8'h02, k);
    host_u.wr(`ADDR_IRQ_PIN_CFG, cfg, k);
    host_u.rd(`ADDR_IRQ_RELEASE, d);
    host_u.wr(`ADDR_MAIN_CTRL, 8'h82, k);
    w(5);
  endtask
  task automatic kick();
    motion_event_in = 1'b1;
    w(1);
    motion_event_in = 1'b0;
    w(5);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    #5_000_000;
    miscompares++;
    give_verdict();
  end
  initial begin
    sys_rst_in = 1'b1;
    {motion_event_in, motion_level_in, reboot_done_in} = 3'h0;
    {tap_event_in, orient_event_in} = 2'h0;
    w(16);
    sys_rst_in = 1'b0;
    w(4);
    for (int i = 0; i < 5; i++) begin
      host_u.rd(ra[i], d);
      chk("reset value", d, rv[i]);
    end
    $display("reset values done");
    for (int i = 1; i < 5; i++) begin
      host_u.wr(ra[i], 8'hFF, k);
      host_u.rd(ra[i], d);
      chk("reserved bits", d, rm[i]);
    end
    host_u.wr(8'h30, 8'h5A, k);
    host_u.rd(8'h30, d);
    chk("unmapped", d, 8'h00);
    chk("alt mask", 8'(tap_alt_mask_enable), 8'h01);
    host_u.wr(`ADDR_MOTION_AXIS, 8'hA0, k);
    chk("axis en", 8'(motion_axis_en_out), 8'h05);
    host_u.wr(`ADDR_TAP_MASK, 8'h15, k);
    chk("tap dir", 8'(tap_dir_en_out), 8'h15);
    chk("alt mask off", 8'(tap_alt_mask_enable), 8'h00);
    $display("reserved bits done");
    for (int i = 0; i < 4; i++) begin
      host_u.wr(`ADDR_RATE_RESET, {1'b0, 2'(i), 1'b0, 2'(i), 2'(i)}, k);
      chk("write ack", 8'(k), 8'h07);
      chk("orient", 8'(orient_rate_out), 8'(i));
      chk("tap", 8'(tap_rate_out), 8'(i));
      chk("motion", 8'(motion_rate_out), 8'(i));
    end
    for (int i = 0; i < 8; i++) begin
      host_u.wr(`ADDR_FILTER_CFG, {2'h0, 2'(i), 1'b0, 3'(i)}, k);
      chk("lowpass", 8'(lowpass_rate_out), 8'(i));
      chk("lp valid", 8'(lowpass_rate_valid_out), 8'(i != 7));
      chk("highpass", 8'(highpass_rolloff_out), 8'(i % 4));
    end
    $display("rate fields done");
    host_u.wr(`ADDR_RATE_RESET, 8'h5D, k);
    host_u.rd(`ADDR_SELFTEST_RESP, d);
    chk("selftest set", d, `SELFTEST_SET);
    host_u.rd(`ADDR_RATE_RESET, d);
    chk("selftest bit", d, 8'h4D);
    host_u.rd(`ADDR_SELFTEST_RESP, d);
    chk("selftest done", d, `SELFTEST_DONE);
    $display("self test done");
    arm(8'h30);
    chk("pin driven", 8'(irq_pin_oe_n_out), 8'h00);
    chk("op mode", 8'(operating_mode_bit), 8'h01);
    kick();
    w(600);
    chk("latched", 8'(irq_pin_out), 8'h01);
    host_u.rd(`ADDR_IRQ_RELEASE, d);
    chk("released", 8'(irq_pin_out), 8'h00);
    tap_event_in = 1'b1;
    w(1);
    tap_event_in = 1'b0;
    w(5);
    chk("tap latched", 8'(irq_pin_out), 8'h01);
    arm(8'h20);
    chk("low idle", 8'(irq_pin_out), 8'h01);
    kick();
    chk("low active", 8'(irq_pin_out), 8'h00);
    arm(8'h38);
    kick();
    w(284);
    chk("pulse on", 8'(irq_pin_out), 8'h01);
    w(230);
    chk("pulse off", 8'(irq_pin_out), 8'h00);
    arm(8'h34);
    motion_level_in = 1'b1;
    w(5);
    chk("follow on", 8'(irq_pin_out), 8'h01);
    motion_level_in = 1'b0;
    w(5);
    chk("follow off", 8'(irq_pin_out), 8'h00);
    arm(8'h10);
    chk("pin off", 8'(irq_pin_oe_n_out), 8'h01);
    $display("irq pin modes done");
    host_u.wr(`ADDR_RATE_RESET, 8'hCD, k);
    chk("reboot nack", 8'(k), 8'h06);
    chk("reboot busy", 8'(reboot_busy_out), 8'h01);
    w(100);
    reboot_done_in = 1'b1;
    for (int i = 0; i < 200 && reboot_busy_out; i++) w(1);
    reboot_done_in = 1'b0;
    chk("reboot end", 8'(reboot_busy_out), 8'h00);
    host_u.rd(`ADDR_RATE_RESET, d);
    chk("reboot bit", 8'(d[7]), 8'h00);
    $display("soft reboot done");
    give_verdict();
  end
endmodule // accel_feature_config_regs_tb_top
`default_nettype wire
